// ===== pasc_pkg.sv
package pasc_pkg;
  // register addresses on the management bus
  localparam logic [4:0] PASC_ADDR_CTRL_ZERO = 5'h11;
  localparam logic [4:0] PASC_ADDR_CTRL_ONE = 5'h12;
  localparam logic [4:0] PASC_ADDR_CTRL_TWO = 5'h13;
  localparam logic [4:0] PASC_ADDR_CTRL_THREE = 5'h14;
  // field positions
  localparam int PASC_POS_PD_SLOW_OSC = 6;
  localparam int PASC_POS_SWING_LSB = 12;
  localparam int PASC_POS_DET_HIGH = 15;
  localparam int PASC_POS_DS_SLOW_OSC = 0;
  localparam int PASC_POS_SLEEP_METHOD = 6;
  localparam int PASC_POS_MANUAL_SLEEP = 5;
  localparam int PASC_POS_RETAIN_EN = 4;
  localparam int PASC_POS_SLEEP_EN = 3;
  // reset values
  localparam logic [15:0] PASC_RST_CTRL_ZERO = 16'h0000;
  localparam logic [15:0] PASC_RST_CTRL_ONE = 16'h0000;
  localparam logic [15:0] PASC_RST_CTRL_TWO = 16'h0000;
  localparam logic [15:0] PASC_RST_CTRL_THREE = 16'h0000;
  // retained-copy masks: all of ctrl three, bits 9:8 and 1:0 of ctrl two
  localparam logic [15:0] PASC_RETAIN_MASK_TWO = 16'h0303;
  localparam logic [15:0] PASC_RETAIN_MASK_THREE = 16'hFFFF;
  // sleep state encoding
  typedef enum logic [1:0] {
    PASC_AWAKE = 2'b00,
    PASC_AUTO_SLEEP = 2'b01,
    PASC_MANUAL_SLEEP = 2'b10
  } pasc_sleep_t;
endpackage : pasc_pkg

// ===== pasc_sleep_fsm.sv
`timescale 1ns/10ps
module pasc_sleep_fsm
  import pasc_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic clk_en, // freezes state when low
  input wire logic sleep_en, // deep sleep permitted
  input wire logic method_cpu, // processor-controlled method
  input wire logic manual_cmd, // manual sleep command bit
  input wire logic energy_det, // cable energy present
  output pasc_sleep_t state // current sleep state
);
  pasc_sleep_t state_ff;
  pasc_sleep_t nxt_state;

  // next state; manual sleep is a trap, only reset leaves it
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PASC_AWAKE: begin
        if (sleep_en && method_cpu && manual_cmd) begin
          nxt_state = PASC_MANUAL_SLEEP;
        end else if (sleep_en && !method_cpu && !energy_det) begin
          nxt_state = PASC_AUTO_SLEEP;
        end
      end
      PASC_AUTO_SLEEP: begin
        // manual command goes straight over, no awake cycle between
        if (sleep_en && method_cpu && manual_cmd) begin
          nxt_state = PASC_MANUAL_SLEEP;
        // energy return or a policy change wakes the device
        end else if (energy_det || !sleep_en || method_cpu) begin
          nxt_state = PASC_AWAKE;
        end
      end
      PASC_MANUAL_SLEEP: begin
        nxt_state = PASC_MANUAL_SLEEP;
      end
      default: nxt_state = PASC_AWAKE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff <= PASC_AWAKE;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  assign state = state_ff;
endmodule : pasc_sleep_fsm

// ===== pasc_afe_ctrl.sv
// Operation
// - ctrl-zero bit 6 selects slow osc in powerdown
// - ctrl-one 15:12 trims fast transmit swing
// - ctrl-two bit 15 enables high comparator
// - ctrl-two bit 0 slow osc in sleep
// - method bit set means manual-only entry
// - manual bit one enters deep standby
// - manual sleep exits only by hardware reset
// - retain bit enables retained register copy
// - sleep enable permits only, forces detect true when clear
`timescale 1ns/10ps
module pasc_afe_ctrl
  import pasc_pkg::*;
(
  input wire logic clk_sys, // 250 MHz reference clock
  input wire logic rstn, // hardware reset, active low
  input wire logic clk_en, // freezes all state when low
  input wire logic reg_wr, // management write strobe
  input wire logic reg_rd, // management read strobe
  input wire logic [4:0] reg_addr, // management register address
  input wire logic [15:0] reg_wdata, // management write data
  input wire logic energy_det, // cable energy detected
  input wire logic power_down, // device in power down
  output logic [15:0] reg_rdata, // read data, registered
  output logic reg_hit, // address belonged to this group
  output logic slow_osc_sel, // slow oscillator replaces 25 MHz
  output logic [3:0] fast_tx_swing_trim, // transmit amplitude code
  output logic det_high_en, // high threshold comparator on
  output logic deep_sleep, // device in deep sleep
  output logic sig_detect, // signal-detect indication
  output logic retained_copy_enable, // retained register copy on
  output logic [15:0] retain_mask_two, // ctrl-two bits held in retained copy
  output logic [15:0] retain_mask_three // ctrl-three bits held in retained copy
);
  logic [15:0] ctrl_zero_ff;
  logic [15:0] ctrl_one_ff;
  logic [15:0] ctrl_two_ff;
  logic [15:0] ctrl_three_ff;
  logic [15:0] rdata_ff;
  logic hit_ff;
  logic slow_osc_ff;
  logic [3:0] swing_ff;
  logic det_high_ff;
  logic sleep_ff;
  logic sigdet_ff;
  logic retain_ff;
  logic [15:0] mask_two_ff;
  logic [15:0] mask_three_ff;
  pasc_sleep_t sleep_state;

  // address decode
  wire sel_zero = (reg_addr == PASC_ADDR_CTRL_ZERO);
  wire sel_one = (reg_addr == PASC_ADDR_CTRL_ONE);
  wire sel_two = (reg_addr == PASC_ADDR_CTRL_TWO);
  wire sel_three = (reg_addr == PASC_ADDR_CTRL_THREE);
  wire sel_any = sel_zero | sel_one | sel_two | sel_three;

  // read mux; unmapped addresses read zero
  wire [15:0] nxt_rdata = sel_zero ? ctrl_zero_ff :
                          sel_one ? ctrl_one_ff :
                          sel_two ? ctrl_two_ff :
                          sel_three ? ctrl_three_ff : 16'h0000;

  // field taps
  wire pd_slow = ctrl_zero_ff[PASC_POS_PD_SLOW_OSC];
  wire ds_slow = ctrl_two_ff[PASC_POS_DS_SLOW_OSC];
  wire sleep_en = ctrl_three_ff[PASC_POS_SLEEP_EN];
  wire method_cpu = ctrl_three_ff[PASC_POS_SLEEP_METHOD];
  wire manual_cmd = ctrl_three_ff[PASC_POS_MANUAL_SLEEP];
  wire in_sleep = (sleep_state != PASC_AWAKE);

  wire nxt_slow_pd = pd_slow & power_down;
  wire nxt_slow_ds = ds_slow & in_sleep;
  wire nxt_sigdet = sleep_en ? energy_det : 1'b1;
  wire [3:0] nxt_swing = ctrl_one_ff[PASC_POS_SWING_LSB +: 4];
  wire nxt_det_high = ctrl_two_ff[PASC_POS_DET_HIGH];
  // retained copy masks follow the enable bit
  wire nxt_retain = ctrl_three_ff[PASC_POS_RETAIN_EN];
  wire [15:0] nxt_mask_two = nxt_retain ? PASC_RETAIN_MASK_TWO : 16'h0000;
  wire [15:0] nxt_mask_three = nxt_retain ? PASC_RETAIN_MASK_THREE : 16'h0000;

  // accepted strobes; a low clock enable turns every access into a no-op
  wire wr_take = clk_en & reg_wr;
  wire rd_take = clk_en & reg_rd;
  wire wr_zero = wr_take & sel_zero;
  wire wr_one = wr_take & sel_one;
  wire wr_two = wr_take & sel_two;
  wire wr_three = wr_take & sel_three;

  // register writes; every bit stored so reserved bits read back
  // reserved bits stored plainly
  // control zero: power-down oscillator choice
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_zero_ff <= PASC_RST_CTRL_ZERO;
    end else if (wr_zero) begin
      ctrl_zero_ff <= reg_wdata;
    end
  end

  // control one: transmit swing trim
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_one_ff <= PASC_RST_CTRL_ONE;
    end else if (wr_one) begin
      ctrl_one_ff <= reg_wdata;
    end
  end

  // control two: comparator threshold and sleep oscillator
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_two_ff <= PASC_RST_CTRL_TWO;
    end else if (wr_two) begin
      ctrl_two_ff <= reg_wdata;
    end
  end

  // control three: sleep policy; a write here cannot undo a manual sleep
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_three_ff <= PASC_RST_CTRL_THREE;
    end else if (wr_three) begin
      ctrl_three_ff <= reg_wdata;
    end
  end

  // read port, answered one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 16'h0000;
      hit_ff <= 1'b0;
    end else if (rd_take) begin
      rdata_ff <= nxt_rdata;
      hit_ff <= sel_any;
    end
  end

  pasc_sleep_fsm u_sleep (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clk_en(clk_en),
    .sleep_en(sleep_en),
    .method_cpu(method_cpu),
    .manual_cmd(manual_cmd),
    .energy_det(energy_det),
    .state(sleep_state)
  );

  // slow clock choice held in a flop so the clock switch sees no glitch
  // the same flop also covers deep sleep
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      slow_osc_ff <= 1'b0;
    end else if (clk_en) begin
      slow_osc_ff <= nxt_slow_pd | nxt_slow_ds;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      swing_ff <= 4'h0;
    end else if (clk_en) begin
      swing_ff <= nxt_swing;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      det_high_ff <= 1'b0;
    end else if (clk_en) begin
      det_high_ff <= nxt_det_high;
    end
  end

  // deep sleep indication, one cycle behind the sleep state
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sleep_ff <= 1'b0;
    end else if (clk_en) begin
      sleep_ff <= in_sleep;
    end
  end

  // signal detect resets true, so no false loss is reported
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sigdet_ff <= 1'b1;
    end else if (clk_en) begin
      sigdet_ff <= nxt_sigdet;
    end
  end

  // retained copy gating and its masks, updated together
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      retain_ff <= 1'b0;
      mask_two_ff <= 16'h0000;
      mask_three_ff <= 16'h0000;
    end else if (clk_en) begin
      retain_ff <= nxt_retain;
      mask_two_ff <= nxt_mask_two;
      mask_three_ff <= nxt_mask_three;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_hit = hit_ff;
  assign slow_osc_sel = slow_osc_ff;
  assign fast_tx_swing_trim = swing_ff;
  assign det_high_en = det_high_ff;
  assign deep_sleep = sleep_ff;
  assign sig_detect = sigdet_ff;
  assign retained_copy_enable = retain_ff;
  assign retain_mask_two = mask_two_ff;
  assign retain_mask_three = mask_three_ff;
endmodule : pasc_afe_ctrl

// ===== pasc_afe_ctrl_sva.sv
`timescale 1ns/10ps
module pasc_afe_ctrl_sva
  import pasc_pkg::*;
(
  input wire logic clk_sys, // reference clock
  input wire logic rstn, // hardware reset, active low
  input wire logic clk_en, // clock enable
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [4:0] reg_addr, // register address
  input wire logic [15:0] reg_wdata, // write data
  input wire logic [15:0] reg_rdata, // read data
  input wire logic reg_hit, // read hit a mapped address
  input wire logic [3:0] fast_tx_swing_trim, // trim code
  input wire logic det_high_en, // high comparator on
  input wire logic deep_sleep, // deep sleep indication
  input wire logic sig_detect, // signal detect
  input wire logic retained_copy_enable, // retained copy on
  input wire logic [15:0] retain_mask_two, // ctrl-two retained bits
  input wire logic [15:0] retain_mask_three // ctrl-three retained bits
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // accepted write to one register
  sequence wr_at(logic [4:0] a);
    reg_wr && clk_en && reg_addr == a;
  endsequence
  // write that commands manual sleep with sleep permitted
  sequence manual_wr_s;
    wr_at(PASC_ADDR_CTRL_THREE) ##0 reg_wdata[6:5] == 2'b11 && reg_wdata[3];
  endsequence
  wire mapped = reg_addr >= PASC_ADDR_CTRL_ZERO && reg_addr <= PASC_ADDR_CTRL_THREE; // group range
  swing_trim_a: assert property (wr_at(PASC_ADDR_CTRL_ONE) ##1 clk_en |=>
    fast_tx_swing_trim == $past(reg_wdata[15:12], 2)) else $error("swing trim wrong");
  comp_high_a: assert property (wr_at(PASC_ADDR_CTRL_TWO) ##1 clk_en |=>
    det_high_en == $past(reg_wdata[15], 2)) else $error("comparator enable wrong");
  retain_mask_a: assert property (retain_mask_two ==
    (retained_copy_enable ? PASC_RETAIN_MASK_TWO : 16'h0000)) else $error("retain mask wrong");
  retain_all_a: assert property (retain_mask_three ==
    (retained_copy_enable ? PASC_RETAIN_MASK_THREE : 16'h0000)) else $error("retain mask three wrong");
  sig_forced_a: assert property (wr_at(PASC_ADDR_CTRL_THREE) ##0 !reg_wdata[3] ##1 clk_en |=> sig_detect)
    else $error("signal detect not forced");
  manual_hold_a: assert property (manual_wr_s ##1 clk_en [*2] |=> deep_sleep [*8])
    else $error("manual sleep not held");
  cpu_method_a: assert property (wr_at(PASC_ADDR_CTRL_THREE) ##0 reg_wdata[6:5] == 2'b10 ##1 clk_en
    ##1 !deep_sleep |=> !deep_sleep) else $error("sleep without command");
  miss_read_a: assert property (reg_rd && clk_en && !mapped |=> !reg_hit && reg_rdata == 16'h0000)
    else $error("unmapped read answered");
  hit_read_a: assert property (reg_rd && clk_en && mapped |=> reg_hit) else $error("mapped read missed");
endmodule : pasc_afe_ctrl_sva
bind pasc_afe_ctrl pasc_afe_ctrl_sva u_sva (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .deep_sleep(deep_sleep), .sig_detect(sig_detect), .det_high_en(det_high_en),
  .retained_copy_enable(retained_copy_enable), .reg_hit(reg_hit), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .retain_mask_two(retain_mask_two), .retain_mask_three(retain_mask_three),
  .fast_tx_swing_trim(fast_tx_swing_trim));

// ===== pasc_cable_model.sv
`timescale 1ns/10ps
module pasc_cable_model (
  input wire logic clk_sys, // reference clock
  input wire logic cable_live, // bench asks for energy on the line
  output logic energy_det // energy seen on the cable
);
  // energy moves off the sampling edge so the block never races it
  always @(negedge clk_sys) begin
    energy_det <= cable_live;
  end
endmodule : pasc_cable_model

// ===== pasc_afe_ctrl_tb.sv
`timescale 1ns/10ps
module pasc_afe_ctrl_tb;
  import pasc_pkg::*;
  logic clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, power_down = 1'b0, cable_live = 1'b1;
  logic clk_en = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, retain_mask_two, retain_mask_three;
  logic [3:0] swing;
  logic energy_det, reg_hit, slow_osc_sel, det_high_en, deep_sleep, sig_detect, retained_copy_enable;
  logic [3:0] codes [3] = '{4'h8, 4'h7, 4'h0};
  int mismatches = 0;
  int samples_checked = 0;
  always #2 clk_sys = ~clk_sys;
  pasc_cable_model u_pasc_cable_model (.clk_sys(clk_sys), .cable_live(cable_live), .energy_det(energy_det));
  pasc_afe_ctrl u_pasc_afe_ctrl (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .energy_det(energy_det), .power_down(power_down),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .slow_osc_sel(slow_osc_sel), .fast_tx_swing_trim(swing),
    .det_high_en(det_high_en), .deep_sleep(deep_sleep), .sig_detect(sig_detect),
    .retained_copy_enable(retained_copy_enable), .retain_mask_two(retain_mask_two),
    .retain_mask_three(retain_mask_three));
  task automatic give_verdict;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : idle
  // one-cycle strobes launched at the falling edge
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask : rd
  // limit is about fifty times the longest run of the sequence below
  initial begin
    #20000;
    mismatches++;
    give_verdict();
  end
  initial begin
    idle(16);
    rstn = 1'b1;
    chk(sig_detect, 1'b1);
    for (int a = 17; a <= 20; a++) begin
      rd(a[4:0], 16'h0000);
      wr(a[4:0], 16'hA5A6);
      rd(a[4:0], 16'hA5A6);
    end
    rd(5'h15, 16'h0000);
    chk(reg_hit, 1'b0);
    foreach (codes[i]) begin
      wr(PASC_ADDR_CTRL_ONE, {codes[i], 12'h000});
      idle(1);
      chk(swing, codes[i]);
    end
    // frozen clock enable: the write and the trim must both be ignored
    clk_en = 1'b0;
    wr(PASC_ADDR_CTRL_ONE, 16'h5000);
    idle(1);
    chk(swing, 4'h0);
    clk_en = 1'b1;
    rd(PASC_ADDR_CTRL_ONE, 16'h0000);
    wr(PASC_ADDR_CTRL_TWO, 16'h8001); // high threshold for large pulses
    idle(1);
    chk(det_high_en, 1'b1);
    wr(PASC_ADDR_CTRL_ZERO, 16'h0040);
    power_down = 1'b1;
    idle(2);
    chk(slow_osc_sel, 1'b1);
    wr(PASC_ADDR_CTRL_ZERO, 16'h0000);
    idle(2);
    chk(slow_osc_sel, 1'b0);
    power_down = 1'b0;
    wr(PASC_ADDR_CTRL_THREE, 16'h0018); // retain set with sleep enable
    cable_live <= 1'b0;
    idle(4);
    chk(deep_sleep, 1'b1);
    chk(slow_osc_sel, 1'b1);
    chk(retained_copy_enable, 1'b1);
    chk(retain_mask_two, 16'h0303);
    chk(retain_mask_three, 16'hFFFF);
    chk(sig_detect, 1'b0);
    cable_live <= 1'b1;
    idle(4);
    chk(deep_sleep, 1'b0);
    wr(PASC_ADDR_CTRL_THREE, 16'h0058);
    cable_live <= 1'b0;
    idle(4);
    chk(deep_sleep, 1'b0);
    wr(PASC_ADDR_CTRL_THREE, 16'h0078);
    idle(2);
    chk(deep_sleep, 1'b1);
    cable_live <= 1'b1;
    wr(PASC_ADDR_CTRL_THREE, 16'h0000);
    idle(4);
    chk(deep_sleep, 1'b1);
    chk(retain_mask_three, 16'h0000);
    rstn = 1'b0;
    idle(2);
    rstn = 1'b1;
    chk(deep_sleep, 1'b0);
    rd(PASC_ADDR_CTRL_THREE, 16'h0000);
    give_verdict();
  end
endmodule : pasc_afe_ctrl_tb
